// [hw/alpr_pkg.sv]
// Package for the alarm and lane polarity register slice
package alpr_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [7:0] ALPR_IDX_TEMP_THRESH = 8'h1b;
  localparam logic [7:0] ALPR_IDX_CSI_EN = 8'h1c;
  localparam logic [7:0] ALPR_IDX_LIMIT_EN = 8'h1d;
  localparam logic [7:0] ALPR_IDX_BC_EN = 8'h1e;
  localparam logic [7:0] ALPR_IDX_RSVD_1F = 8'h1f;
  localparam logic [7:0] ALPR_IDX_HS_SWAP = 8'h20;
  localparam logic [7:0] ALPR_IDX_LP_SWAP = 8'h21;
  localparam logic [7:0] ALPR_IDX_HS_DBG = 8'h22;
  localparam logic [7:0] ALPR_IDX_LP_DBG = 8'h23;
  localparam logic [7:0] ALPR_IDX_TERM_DBG = 8'h24;
  localparam logic [7:0] ALPR_IDX_RSVD_25 = 8'h25;
  localparam logic [7:0] ALPR_IDX_RSVD_26 = 8'h26;
  localparam logic [7:0] ALPR_IDX_RSVD_27 = 8'h27;
  localparam logic [7:0] ALPR_IDX_ALARM_STAT = 8'h30;
  localparam logic [7:0] ALPR_IDX_ALARM_MASK = 8'h31;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] ALPR_RST_TEMP_THRESH = 8'h62;
  localparam logic [7:0] ALPR_RST_CSI_EN = 8'h3f;
  localparam logic [7:0] ALPR_RST_ZERO = 8'h00;
  localparam logic [7:0] ALPR_RST_RSVD_25 = 8'h02;

  // --------------------------------------------------------------------------
  // Field positions and writable masks
  // --------------------------------------------------------------------------
  localparam int ALPR_TEMP_HI_LSB = 4;
  localparam int ALPR_TEMP_LO_LSB = 0;
  localparam int ALPR_CLK_LANE_BIT = 4;
  localparam logic [7:0] ALPR_WM_THRESH = 8'h77;
  localparam logic [7:0] ALPR_WM_CSI = 8'h3f;
  localparam logic [7:0] ALPR_WM_LIMIT = 8'h3f;
  localparam logic [7:0] ALPR_WM_BC = 8'h7f;
  localparam logic [7:0] ALPR_WM_ALL = 8'hff;
  localparam logic [7:0] ALPR_WM_HS_SWAP = 8'h1f;
  localparam logic [7:0] ALPR_WM_LOW7 = 8'h7f;
  localparam logic [7:0] ALPR_WM_LOW3 = 8'h07;
  localparam logic [7:0] ALPR_WM_SPLIT = 8'h77;

  // Alarm status bit positions
  localparam int ALPR_ST_CSI = 0;
  localparam int ALPR_ST_LIMIT = 1;
  localparam int ALPR_ST_BC = 2;
  localparam int ALPR_ST_TEMP_HI = 3;
  localparam int ALPR_ST_TEMP_LO = 4;
  localparam logic [7:0] ALPR_WM_MASK = 8'h1f;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic missing_frame_valid;
    logic lane_sync_error;
    logic lane_control_error;
    logic header_double_error;
    logic payload_checksum;
    logic packet_length;
  } alpr_csi_err_t;

  typedef struct packed {
    logic temp_over;
    logic temp_under;
    logic volt1_over;
    logic volt1_under;
    logic volt0_over;
    logic volt0_under;
  } alpr_limit_t;

  typedef struct packed {
    logic clk_p;
    logic clk_n;
    logic [3:0] data_p;
    logic [3:0] data_n;
  } alpr_lanes_t;

endpackage

// [hw/alpr_regs.sv]
// Alarm enable, threshold and lane polarity register slice with Wishbone slave

module alpr_regs
  import alpr_pkg::*;
#(
  parameter int TEMP_W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Sensor measurement and detected errors
  input wire logic temp_sensor_en_i,
  input wire logic [TEMP_W-1:0] temp_level_i,
  input wire alpr_csi_err_t csi_err_i,
  input wire alpr_limit_t volt_limit_i,
  input wire logic [6:0] bc_err_i,
  // Lanes from the image sensor
  input wire alpr_lanes_t hs_lanes_i,
  input wire alpr_lanes_t lp_lanes_i,
  input wire logic lp_mode_i,
  // Gated alarms and conditioned lanes
  output logic temp_high_flag_o,
  output logic temp_low_flag_o,
  output alpr_csi_err_t csi_alarm_o,
  output alpr_limit_t limit_alarm_o,
  output logic [6:0] bc_alarm_o,
  output alpr_lanes_t lanes_o,
  output logic [6:0] hs_rx_debug_o,
  output logic [6:0] lp_rx_debug_o,
  output logic [3:0] lane_termination_on_o,
  output logic irq_o
);

  // Elaboration check: the comparators and field slices serve three-bit codes only
  if (TEMP_W != 3) begin : g_bad_temp_w
    $error("alpr_regs: temperature fields are three bits wide");
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] thresh_reg, csi_en_reg, limit_en_reg, bc_en_reg, rsvd_1f_reg;
  logic [7:0] hs_swap_reg, lp_swap_reg, hs_dbg_reg, lp_dbg_reg, term_reg;
  logic [7:0] rsvd_25_reg, rsvd_26_reg, rsvd_27_reg;
  logic [7:0] stat_reg, mask_reg;
  logic temp_hi_reg, temp_lo_reg;
  logic [7:0] stat_next;
  logic ack_reg;
  logic [31:0] dat_reg;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // A request is masked while its answer stands, so ack and err pulse once
  wire logic req = cyc_i && stb_i && !ack_reg && !err_o;
  wire logic [7:0] idx = adr_i[9:2];
  wire logic aligned = (adr_i[1:0] == 2'b00);
  wire logic wr_lane = we_i && sel_i[0];
  wire logic hit_thr = idx == ALPR_IDX_TEMP_THRESH;
  wire logic hit_csi = idx == ALPR_IDX_CSI_EN;
  wire logic hit_lim = idx == ALPR_IDX_LIMIT_EN;
  wire logic hit_bc = idx == ALPR_IDX_BC_EN;
  wire logic hit_1f = idx == ALPR_IDX_RSVD_1F;
  wire logic hit_hs = idx == ALPR_IDX_HS_SWAP;
  wire logic hit_lp = idx == ALPR_IDX_LP_SWAP;
  wire logic hit_hd = idx == ALPR_IDX_HS_DBG;
  wire logic hit_ld = idx == ALPR_IDX_LP_DBG;
  wire logic hit_tm = idx == ALPR_IDX_TERM_DBG;
  wire logic hit_25 = idx == ALPR_IDX_RSVD_25;
  wire logic hit_26 = idx == ALPR_IDX_RSVD_26;
  wire logic hit_27 = idx == ALPR_IDX_RSVD_27;
  wire logic hit_st = idx == ALPR_IDX_ALARM_STAT;
  wire logic hit_mk = idx == ALPR_IDX_ALARM_MASK;
  wire logic mapped = aligned && (hit_thr || hit_csi || hit_lim || hit_bc || hit_1f
    || hit_hs || hit_lp || hit_hd || hit_ld || hit_tm || hit_25 || hit_26
    || hit_27 || hit_st || hit_mk);
  wire logic do_wr = req && mapped && wr_lane;
  wire logic do_rd = req && mapped && !we_i;
  wire logic [7:0] wd = dat_i[7:0];

  wire logic [7:0] rd_mux =
    hit_thr ? thresh_reg : hit_csi ? csi_en_reg : hit_lim ? limit_en_reg :
    hit_bc ? bc_en_reg : hit_1f ? rsvd_1f_reg : hit_hs ? hs_swap_reg :
    hit_lp ? lp_swap_reg : hit_hd ? hs_dbg_reg : hit_ld ? lp_dbg_reg :
    hit_tm ? term_reg : hit_25 ? rsvd_25_reg : hit_26 ? rsvd_26_reg :
    hit_27 ? rsvd_27_reg : hit_st ? stat_reg : hit_mk ? mask_reg : 8'h00;

  // Reserved and read-only bits keep their value; only masked bits change
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wm,
                                       input logic [7:0] nv);
    merge = (old & ~wm) | (nv & wm);
  endfunction

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Limit reset values
      thresh_reg <= ALPR_RST_TEMP_THRESH;
      // CSI enables reset
      csi_en_reg <= ALPR_RST_CSI_EN;
      // Limit enables reset
      limit_en_reg <= ALPR_RST_ZERO;
      // Back-channel reset
      bc_en_reg <= ALPR_RST_ZERO;
      rsvd_1f_reg <= ALPR_RST_ZERO;
      // Swap registers reset
      hs_swap_reg <= ALPR_RST_ZERO;
      lp_swap_reg <= ALPR_RST_ZERO;
      hs_dbg_reg <= ALPR_RST_ZERO;
      lp_dbg_reg <= ALPR_RST_ZERO;
      // Termination reset
      term_reg <= ALPR_RST_ZERO;
      rsvd_25_reg <= ALPR_RST_RSVD_25;
      rsvd_26_reg <= ALPR_RST_ZERO;
      rsvd_27_reg <= ALPR_RST_ZERO;
      mask_reg <= ALPR_RST_ZERO;
    end else if (do_wr) begin
      if (hit_thr) thresh_reg <= merge(thresh_reg, ALPR_WM_THRESH, wd);
      if (hit_csi) csi_en_reg <= merge(csi_en_reg, ALPR_WM_CSI, wd);
      if (hit_lim) limit_en_reg <= merge(limit_en_reg, ALPR_WM_LIMIT, wd);
      if (hit_bc) bc_en_reg <= merge(bc_en_reg, ALPR_WM_BC, wd);
      if (hit_1f) rsvd_1f_reg <= wd;
      if (hit_hs) hs_swap_reg <= merge(hs_swap_reg, ALPR_WM_HS_SWAP, wd);
      if (hit_lp) lp_swap_reg <= wd;
      if (hit_hd) hs_dbg_reg <= merge(hs_dbg_reg, ALPR_WM_LOW7, wd);
      if (hit_ld) lp_dbg_reg <= merge(lp_dbg_reg, ALPR_WM_LOW7, wd);
      if (hit_tm) term_reg <= wd;
      if (hit_25) rsvd_25_reg <= merge(rsvd_25_reg, ALPR_WM_SPLIT, wd);
      if (hit_26) rsvd_26_reg <= merge(rsvd_26_reg, ALPR_WM_SPLIT, wd);
      if (hit_27) rsvd_27_reg <= merge(rsvd_27_reg, ALPR_WM_LOW3, wd);
      if (hit_mk) mask_reg <= merge(mask_reg, ALPR_WM_MASK, wd);
    end
  end

  // --------------------------------------------------------------------------
  // Temperature comparison
  // --------------------------------------------------------------------------
  wire logic [TEMP_W-1:0] temp_upper_limit = thresh_reg[ALPR_TEMP_HI_LSB +: TEMP_W];
  wire logic [TEMP_W-1:0] temp_lower_limit = thresh_reg[ALPR_TEMP_LO_LSB +: TEMP_W];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_hi_reg <= 1'b0;
      temp_lo_reg <= 1'b0;
    end else begin
      temp_hi_reg <= temp_sensor_en_i && (temp_level_i > temp_upper_limit);
      temp_lo_reg <= temp_sensor_en_i && (temp_level_i < temp_lower_limit);
    end
  end

  // --------------------------------------------------------------------------
  // Named enable fields
  // --------------------------------------------------------------------------
  wire logic missing_frame_valid_alarm_en = csi_en_reg[5];
  wire logic lane_sync_error_alarm_en = csi_en_reg[4];
  wire logic lane_control_error_alarm_en = csi_en_reg[3];
  wire logic header_double_error_alarm_en = csi_en_reg[2];
  wire logic payload_checksum_alarm_en = csi_en_reg[1];
  wire logic packet_length_alarm_en = csi_en_reg[0];
  wire logic temp_over_alarm_en = limit_en_reg[5];
  wire logic temp_under_alarm_en = limit_en_reg[4];
  wire logic volt1_over_alarm_en = limit_en_reg[3];
  wire logic volt1_below_alarm_en = limit_en_reg[2];
  wire logic volt0_over_alarm_en = limit_en_reg[1];
  wire logic volt0_below_alarm_en = limit_en_reg[0];
  // Back-channel enables, target timeout down to link detect
  wire logic bc_target_timeout_alarm_en = bc_en_reg[6];
  wire logic bc_target_fault_alarm_en = bc_en_reg[5];
  wire logic bc_controller_timeout_alarm_en = bc_en_reg[4];
  wire logic bc_controller_fault_alarm_en = bc_en_reg[3];
  wire logic bc_data_fault_alarm_en = bc_en_reg[2];
  wire logic bc_crc_alarm_en = bc_en_reg[1];
  wire logic bc_link_detect_alarm_en = bc_en_reg[0];
  wire logic [6:0] bc_alarm_en = {bc_target_timeout_alarm_en, bc_target_fault_alarm_en,
    bc_controller_timeout_alarm_en, bc_controller_fault_alarm_en, bc_data_fault_alarm_en,
    bc_crc_alarm_en, bc_link_detect_alarm_en};

  // --------------------------------------------------------------------------
  // Alarm gating; detection itself is never touched by the enables
  // --------------------------------------------------------------------------
  // frame-valid gate
  wire logic a_fv = csi_err_i.missing_frame_valid & missing_frame_valid_alarm_en;
  wire logic a_sync = csi_err_i.lane_sync_error & lane_sync_error_alarm_en;
  wire logic a_ctrl = csi_err_i.lane_control_error & lane_control_error_alarm_en;
  wire logic a_hdr = csi_err_i.header_double_error & header_double_error_alarm_en;
  wire logic a_sum = csi_err_i.payload_checksum & payload_checksum_alarm_en;
  wire logic a_len = csi_err_i.packet_length & packet_length_alarm_en;
  wire logic a_tov = temp_hi_reg & temp_over_alarm_en;
  wire logic a_tun = temp_lo_reg & temp_under_alarm_en;
  wire logic a_v1o = volt_limit_i.volt1_over & volt1_over_alarm_en;
  wire logic a_v1u = volt_limit_i.volt1_under & volt1_below_alarm_en;
  wire logic a_v0o = volt_limit_i.volt0_over & volt0_over_alarm_en;
  wire logic a_v0u = volt_limit_i.volt0_under & volt0_below_alarm_en;
  wire logic [6:0] a_bc = bc_err_i & bc_alarm_en;
  wire alpr_csi_err_t csi_gated = '{a_fv, a_sync, a_ctrl, a_hdr, a_sum, a_len};
  wire alpr_limit_t lim_gated = '{a_tov, a_tun, a_v1o, a_v1u, a_v0o, a_v0u};

  // --------------------------------------------------------------------------
  // Lane polarity; the low-power set applies while the lanes are in LP mode
  // --------------------------------------------------------------------------
  // high-speed swap select
  wire logic clock_lane_swap = hs_swap_reg[ALPR_CLK_LANE_BIT];
  wire logic data_lane3_swap = hs_swap_reg[3];
  wire logic data_lane2_swap = hs_swap_reg[2];
  wire logic data_lane1_swap = hs_swap_reg[1];
  wire logic data_lane0_swap = hs_swap_reg[0];
  wire logic [3:0] hs_dat_sw = {data_lane3_swap, data_lane2_swap, data_lane1_swap,
    data_lane0_swap};
  wire logic lp_clock_lane_swap = lp_swap_reg[ALPR_CLK_LANE_BIT];
  wire logic [3:0] lp_data_lane_swap = lp_swap_reg[3:0];
  wire alpr_lanes_t src = lp_mode_i ? lp_lanes_i : hs_lanes_i;
  wire logic clk_sw = lp_mode_i ? lp_clock_lane_swap : clock_lane_swap;
  wire logic [3:0] dat_sw = lp_mode_i ? lp_data_lane_swap : hs_dat_sw;
  // exchange P and N lane by lane
  wire logic [3:0] dat_p_sw, dat_n_sw;
  for (genvar ln = 0; ln < 4; ln++) begin : g_lane
    assign dat_p_sw[ln] = dat_sw[ln] ? src.data_n[ln] : src.data_p[ln];
    assign dat_n_sw[ln] = dat_sw[ln] ? src.data_p[ln] : src.data_n[ln];
  end
  wire alpr_lanes_t lanes_next = '{
    clk_sw ? src.clk_n : src.clk_p,
    clk_sw ? src.clk_p : src.clk_n,
    dat_p_sw,
    dat_n_sw};

  // --------------------------------------------------------------------------
  // Sticky alarm status; a read clears it, but a new event wins
  // --------------------------------------------------------------------------
  logic [7:0] events;
  always_comb begin
    events = 8'h00;
    events[ALPR_ST_CSI] = |csi_gated;
    events[ALPR_ST_LIMIT] = |lim_gated;
    events[ALPR_ST_BC] = |a_bc;
    events[ALPR_ST_TEMP_HI] = temp_hi_reg;
    events[ALPR_ST_TEMP_LO] = temp_lo_reg;
  end
  wire logic stat_rd = do_rd && hit_st;
  // The interrupt follows the next status, so a read clear drops it at once
  wire logic irq_next = |(stat_next & mask_reg);

  always_comb begin
    stat_next = stat_rd ? 8'h00 : stat_reg;
    stat_next = stat_next | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= ALPR_RST_ZERO;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // --------------------------------------------------------------------------
  // Bus answer and registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_o <= 1'b0;
      dat_reg <= 32'h0000_0000;
      temp_high_flag_o <= 1'b0;
      temp_low_flag_o <= 1'b0;
      csi_alarm_o <= '0;
      limit_alarm_o <= '0;
      bc_alarm_o <= 7'h00;
      lanes_o <= '0;
      irq_o <= 1'b0;
    end else begin
      ack_reg <= req && mapped;
      err_o <= req && !mapped;
      dat_reg <= (req && mapped && !we_i) ? {24'h000000, rd_mux} : 32'h0000_0000;
      temp_high_flag_o <= temp_hi_reg;
      temp_low_flag_o <= temp_lo_reg;
      csi_alarm_o <= csi_gated;
      limit_alarm_o <= lim_gated;
      bc_alarm_o <= a_bc;
      lanes_o <= lanes_next;
      irq_o <= irq_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign hs_rx_debug_o = hs_dbg_reg[6:0];
  assign lp_rx_debug_o = lp_dbg_reg[6:0];
  // one termination bit per data lane
  wire logic lane3_termination_on = term_reg[3];
  wire logic lane2_termination_on = term_reg[2];
  wire logic lane1_termination_on = term_reg[1];
  wire logic lane0_termination_on = term_reg[0];
  assign lane_termination_on_o = {lane3_termination_on, lane2_termination_on,
    lane1_termination_on, lane0_termination_on};

endmodule

// [verif/alpr_regs_properties.sv]
// Checker for the alarm and lane polarity register slice
module alpr_regs_properties
  import alpr_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Alarms and lanes
  input wire logic temp_sensor_en_i,
  input wire alpr_csi_err_t csi_err_i,
  input wire alpr_limit_t volt_limit_i,
  input wire logic [6:0] bc_err_i,
  input wire alpr_lanes_t hs_lanes_i,
  input wire logic lp_mode_i,
  input wire logic temp_high_flag_o,
  input wire logic temp_low_flag_o,
  input wire alpr_csi_err_t csi_alarm_o,
  input wire alpr_limit_t limit_alarm_o,
  input wire logic [6:0] bc_alarm_o,
  input wire alpr_lanes_t lanes_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i && !ack_o && !err_o;
  property p_answer; req |=> ack_o || err_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_err_pulse; err_o |=> !err_o; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle");
  property p_unaligned; req && adr_i[1:0] != 2'h0 |=> err_o && !ack_o; endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
  property p_dat_high; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
  a_dat_high: assert property (p_dat_high) else $error("read data upper bits not zero");
  property p_csi_gate; (6'(csi_alarm_o) & ~$past(6'(csi_err_i))) == 6'h00; endproperty
  a_csi_gate: assert property (p_csi_gate) else $error("csi alarm without error");
  property p_bc_gate; (bc_alarm_o & ~$past(bc_err_i)) == 7'h00; endproperty
  a_bc_gate: assert property (p_bc_gate) else $error("bc alarm without condition");
  property p_volt_gate; (limit_alarm_o[3:0] & ~$past(volt_limit_i[3:0])) == 4'h0; endproperty
  a_volt_gate: assert property (p_volt_gate) else $error("voltage alarm w/o cause");
  property p_temp_hi; temp_high_flag_o |-> $past(temp_sensor_en_i, 2); endproperty
  a_temp_hi: assert property (p_temp_hi) else $error("high flag with sensor off");
  property p_temp_lo; temp_low_flag_o |-> $past(temp_sensor_en_i, 2); endproperty
  a_temp_lo: assert property (p_temp_lo) else $error("low flag with sensor off");
  // Swapped or straight, a clock pair must come from the same input pair
  property p_clk_pair;
    !$past(rst_i) && !$past(lp_mode_i) |->
      {lanes_o.clk_p, lanes_o.clk_n} == $past({hs_lanes_i.clk_p, hs_lanes_i.clk_n}) ||
      {lanes_o.clk_n, lanes_o.clk_p} == $past({hs_lanes_i.clk_p, hs_lanes_i.clk_n});
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock lane pair corrupted");
endmodule

bind alpr_regs alpr_regs_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i,
  .dat_o, .ack_o, .err_o, .temp_sensor_en_i, .csi_err_i, .volt_limit_i, .bc_err_i,
  .hs_lanes_i, .lp_mode_i, .temp_high_flag_o, .temp_low_flag_o, .csi_alarm_o,
  .limit_alarm_o, .bc_alarm_o, .lanes_o);

// [verif/alpr_sensor_model.sv]
// Image sensor model driving the high-speed and low-power lanes
module alpr_sensor_model
  import alpr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Lanes toward the slice
  output alpr_lanes_t hs_lanes_o,
  output alpr_lanes_t lp_lanes_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines change every cycle so a stale sample cannot match by luck
  logic [9:0] seq_reg = 10'h2a5;
  always_ff @(posedge clk_i) begin
    seq_reg <= rst_i ? 10'h2a5 : seq_reg + 10'h0cb;
  end
  assign hs_lanes_o = alpr_lanes_t'(seq_reg);
  assign lp_lanes_o = alpr_lanes_t'(~{seq_reg[4:0], seq_reg[9:5]});
endmodule

// [verif/tb_alpr_regs.sv]
// Self-checking bench for the alarm and lane polarity register slice
module tb_alpr_regs
  import alpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic temp_sensor_en_i = 1'b0, lp_mode_i = 1'b0, er;
  logic [2:0] temp_level_i = 3'h4;
  alpr_csi_err_t csi_err_i = 6'h00, csi_alarm_o;
  alpr_limit_t volt_limit_i = 6'h00, limit_alarm_o;
  logic [6:0] bc_err_i = 7'h00, bc_alarm_o, hs_rx_debug_o, lp_rx_debug_o;
  alpr_lanes_t hs_lanes_i, lp_lanes_i, lanes_o, cap;
  logic ack_o, err_o, temp_high_flag_o, temp_low_flag_o, irq_o;
  logic [3:0] lane_termination_on_o;
  logic [7:0] rd;
  logic [3:0] wsel = 4'h1;
  int err_total = 0;
  int samples_checked = 0;
  typedef struct packed {logic [7:0] idx; logic [7:0] rst; logic [7:0] wm;} alpr_row_t;
  alpr_row_t rows [14] = '{'{8'h1b, 8'h62, 8'h77}, '{8'h1c, 8'h3f, 8'h3f},
    '{8'h1d, 8'h00, 8'h3f}, '{8'h1e, 8'h00, 8'h7f}, '{8'h1f, 8'h00, 8'hff},
    '{8'h20, 8'h00, 8'h1f}, '{8'h21, 8'h00, 8'hff}, '{8'h22, 8'h00, 8'h7f},
    '{8'h23, 8'h00, 8'h7f}, '{8'h24, 8'h00, 8'hff}, '{8'h25, 8'h02, 8'h77},
    '{8'h26, 8'h00, 8'h77}, '{8'h27, 8'h00, 8'h07}, '{8'h31, 8'h00, 8'h1f}};
  always #50 clk_i = ~clk_i;
  alpr_regs #(.TEMP_W(3)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .temp_sensor_en_i, .temp_level_i, .csi_err_i,
    .volt_limit_i, .bc_err_i, .hs_lanes_i, .lp_lanes_i, .lp_mode_i, .temp_high_flag_o,
    .temp_low_flag_o, .csi_alarm_o, .limit_alarm_o, .bc_alarm_o, .lanes_o, .hs_rx_debug_o,
    .lp_rx_debug_o, .lane_termination_on_o, .irq_o);
  alpr_sensor_model u_sensor (.clk_i, .rst_i, .hs_lanes_o(hs_lanes_i), .lp_lanes_o(lp_lanes_i));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Master waits on ack or err without assuming a latency; watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] idx, input logic [1:0] lo,
                    input logic [7:0] wd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, lo};
    dat_i <= {24'h000000, wd};
    sel_i <= wsel;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o[7:0];
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 2'h0, 8'h00);
    chk(32'(rd), 32'(exp));
  endtask
  task automatic tcase(input logic en, input logic [2:0] lvl, input logic [1:0] fl);
    @(posedge clk_i);
    temp_sensor_en_i <= en;
    temp_level_i <= lvl;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'({temp_high_flag_o, temp_low_flag_o}), 32'(fl));
    chk(32'(limit_alarm_o[5:4]), 32'(fl));
  endtask
  function automatic alpr_lanes_t swp(input alpr_lanes_t l, input logic [4:0] s);
    swp.clk_p = s[4] ? l.clk_n : l.clk_p;
    swp.clk_n = s[4] ? l.clk_p : l.clk_n;
    swp.data_p = (l.data_p & ~s[3:0]) | (l.data_n & s[3:0]);
    swp.data_n = (l.data_n & ~s[3:0]) | (l.data_p & s[3:0]);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      rdc(rows[i].idx, rows[i].rst);
      wb(1'b1, rows[i].idx, 2'h0, 8'hff);
      rdc(rows[i].idx, rows[i].wm);
      wb(1'b1, rows[i].idx, 2'h0, rows[i].rst);
    end
    chk(32'(hs_rx_debug_o), 32'h0);
    $display("test register table done");
    wb(1'b0, 8'h28, 2'h0, 8'h00);
    chk(32'(er), 32'h1);
    wb(1'b1, 8'h1d, 2'h1, 8'h3f);
    chk(32'(er), 32'h1);
    wsel = 4'h0;
    wb(1'b1, 8'h1d, 2'h0, 8'h3f);
    wsel = 4'h1;
    chk(32'(er), 32'h0);
    rdc(8'h1d, 8'h00);
    $display("test refusals done");
    wb(1'b1, 8'h31, 2'h0, 8'h01);
    wb(1'b1, 8'h1c, 2'h0, 8'h15);
    @(posedge clk_i);
    csi_err_i <= 6'h3f;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(csi_alarm_o), 32'h15);
    wb(1'b1, 8'h1c, 2'h0, 8'h2a);
    @(negedge clk_i);
    chk(32'(csi_alarm_o), 32'h2a);
    @(posedge clk_i);
    csi_err_i <= 6'h00;
    repeat (2) @(negedge clk_i);
    chk(32'(irq_o), 32'h1);
    rdc(8'h30, 8'h01);
    @(negedge clk_i);
    chk(32'(irq_o), 32'h0);
    rdc(8'h30, 8'h00);
    wb(1'b1, 8'h1e, 2'h0, 8'h55);
    @(posedge clk_i);
    bc_err_i <= 7'h7f;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(bc_alarm_o), 32'h55);
    chk(32'(irq_o), 32'h0);
    @(posedge clk_i);
    bc_err_i <= 7'h00;
    rdc(8'h30, 8'h04);
    $display("test alarm gating and interrupt done");
    wb(1'b1, 8'h1d, 2'h0, 8'h3a);
    @(posedge clk_i);
    volt_limit_i <= 6'h3f;
    tcase(1'b1, 3'h7, 2'h2);
    chk(32'(limit_alarm_o[3:0]), 32'ha);
    tcase(1'b1, 3'h6, 2'h0);
    tcase(1'b1, 3'h2, 2'h0);
    tcase(1'b1, 3'h1, 2'h1);
    tcase(1'b0, 3'h7, 2'h0);
    wb(1'b1, 8'h1b, 2'h0, 8'h31);
    tcase(1'b1, 3'h4, 2'h2);
    tcase(1'b1, 3'h0, 2'h1);
    $display("test limits done");
    wb(1'b1, 8'h20, 2'h0, 8'h11);
    wb(1'b1, 8'h21, 2'h0, 8'h0a);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_i);
      lp_mode_i <= m[0];
      repeat (2) @(negedge clk_i);
      cap = m[0] ? lp_lanes_i : hs_lanes_i;
      @(negedge clk_i);
      chk(32'(lanes_o), 32'(swp(cap, m[0] ? 5'h0a : 5'h11)));
    end
    wb(1'b1, 8'h24, 2'h0, 8'h0c);
    wb(1'b1, 8'h23, 2'h0, 8'h55);
    chk(32'(lane_termination_on_o), 32'hc);
    chk(32'(lp_rx_debug_o), 32'h55);
    $display("test lanes and debug done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h1c, 8'h3f);
    rdc(8'h20, 8'h00);
    chk(32'(irq_o), 32'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
